// [shared/mbm_pkg.sv]
// Package for the microcontroller buffer address mapper.
// Assumes an 8-bit microcontroller bus and a 20-bit DRAM buffer address.
package mbm_pkg;
   localparam logic [15:0] MBM_PROG_CTRL_ADDR = 16'hf09f;
   localparam logic [15:0] MBM_PAGE_ADDR = 16'hf0ff;
   localparam logic [15:0] MBM_FRM_LO_ADDR = 16'hf0f6;
   localparam logic [15:0] MBM_FRM_HI_ADDR = 16'hf0f7;
   localparam logic [7:0] MBM_PROG_CTRL_RESET = 8'h00;
   localparam logic [7:0] MBM_PAGE_RESET = 8'h00;
   localparam logic [8:0] MBM_FRAME_RESET = 9'h000;
   localparam int MBM_PRG_DATA_BIT = 7;
   localparam int MBM_PRG_WIN_BIT = 6;
   localparam int MBM_PRG_TOP_BIT = 5;
   localparam int MBM_PRG_INV_BIT = 4;
   localparam int MBM_PAGE_W = 5;
   localparam int MBM_PAGE_RD_W = 6;
   localparam logic [19:0] MBM_FRAME_BYTES = 20'h00c00;
   localparam logic [3:0] MBM_REG_NIBBLE = 4'hf;
   typedef enum logic [4:0] {
      MBM_REGION_LINEAR = 5'b00001,
      MBM_REGION_FRAME = 5'b00010,
      MBM_REGION_UNUSED = 5'b00100,
      MBM_REGION_CTRL = 5'b01000,
      MBM_REGION_PROG = 5'b10000
   } mbm_region_t;
endpackage

// [design/mbm_frame_calc.sv]
// Frame window address arithmetic with wrap between start and last frame.
// Assumes start_frame <= last_frame; all inputs on ref_clk.
`timescale 1ns/10ps
module mbm_frame_calc
   import mbm_pkg::*;
(
   input wire logic [8:0] frame_num,
   input wire logic [1:0] frame_sel,
   input wire logic [8:0] start_frame,
   input wire logic [8:0] last_frame,
   input wire logic [11:0] offset,
   output logic [19:0] buf_addr
);
   logic [9:0] raw_sum;
   logic [9:0] over;
   logic [8:0] frame_eff;
   logic [19:0] product;

   assign raw_sum = {1'b0, frame_num} + {8'h00, frame_sel};
   assign over = raw_sum - {1'b0, last_frame};
   // Wrapped frames continue from the start pointer
   assign frame_eff = (raw_sum > {1'b0, last_frame}) ?
      9'(start_frame + over[8:0] - 9'h001) : raw_sum[8:0];
   assign product = 20'(frame_eff * MBM_FRAME_BYTES);
   assign buf_addr = product + {8'h00, offset};
endmodule

// [design/mbm_mapper.sv]
// Top of the microcontroller buffer address mapper.
// Assumes microcontroller strobes are synchronous to ref_clk, one-cycle pulses.
// Functional notes
// - Page bits 4..0 drive buffer address bits 19..15 for linear window accesses.
// - A page register write changes the DRAM address at once, even mid-cycle.
// - Addresses 0000-7fff go to the buffer as linear memory using the page register.
// - Window 8000-8fff addresses frame number times 3 k plus the low 12 address bits.
// - Window 9000-9fff does the same with frame number plus one.
// - Window a000-afff does the same with frame number plus two.
// - Frames past the last pointer wrap to the start pointer onward.
// - Addresses b000-efff start no buffer cycle; buf_addr goes low unless a DRAM access is still running.
// - Program memory remap controls act only while data-as-program is set.
// - Data-as-program steers data accesses to program SRAM and blocks DRAM cycles.
// - Window enable splits program memory into 32 kbyte windows chosen by select.
// - Select low picks the bottom window, high the top window.
// - Invert bit flips program address bit 15 on data accesses.
// - Linear address is low 15 bits plus 32768 times the page value.
// - Frame counter loads on high byte write; low byte must be written first.
// - A frame counter load waits until a running frame-window DRAM access ends.
`timescale 1ns/10ps
module mbm_mapper
   import mbm_pkg::*;
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic [15:0] mcu_addr,
   input wire logic [7:0] mcu_wdata,
   input wire logic mcu_data_rd,
   input wire logic mcu_data_wr,
   input wire logic mcu_prog_rd,
   input wire logic dram_done,
   input wire logic [8:0] start_frame_pointer,
   input wire logic [8:0] last_frame_pointer,
   output logic [19:0] buf_addr,
   output logic dram_req,
   output logic [15:0] prog_addr,
   output logic prog_req,
   output logic reg_sel,
   output logic [7:0] reg_rdata
);
   logic [7:0] prog_ctrl_reg;
   logic [MBM_PAGE_W-1:0] page_reg;
   logic [7:0] frm_lo_reg;
   logic [8:0] micro_frame_number;
   logic frm_pend_reg;
   logic [8:0] frm_pend_val_reg;
   logic frm_busy_reg;
   logic [19:0] buf_addr_reg;
   logic dram_req_reg;
   logic [15:0] prog_addr_reg;
   logic prog_req_reg;
   logic reg_sel_reg;
   logic [7:0] reg_rdata_reg;
   logic [15:0] cur_addr_reg;
   logic cur_lin_reg;
   mbm_region_t region;
   logic data_acc;
   logic data_as_program;
   logic program_window_enable;
   logic sel_top;
   logic invert_top_address_bit;
   logic [19:0] frame_addr;
   logic [19:0] lin_addr;
   logic [19:0] buf_next;
   logic [15:0] prog_next;
   logic prog_top;
   logic dram_next;
   logic frm_load;
   logic [7:0] rd_next;

   function automatic mbm_region_t mbm_decode(input logic [15:0] a);
      if (!a[15])
         return MBM_REGION_LINEAR;
      else if (a[14:12] <= 3'h2)
         return MBM_REGION_FRAME;
      else if (a[15:12] == MBM_REG_NIBBLE)
         return MBM_REGION_CTRL;
      else
         return MBM_REGION_UNUSED;
   endfunction

   assign data_acc = mcu_data_rd | mcu_data_wr;
   assign region = mbm_decode(mcu_addr);
   assign data_as_program = prog_ctrl_reg[MBM_PRG_DATA_BIT];
   assign program_window_enable = data_as_program & prog_ctrl_reg[MBM_PRG_WIN_BIT];
   assign sel_top = prog_ctrl_reg[MBM_PRG_TOP_BIT];
   assign invert_top_address_bit = data_as_program & prog_ctrl_reg[MBM_PRG_INV_BIT];

   mbm_frame_calc u_frame_calc (
      .frame_num(micro_frame_number),
      .frame_sel(mcu_addr[13:12]),
      .start_frame(start_frame_pointer),
      .last_frame(last_frame_pointer),
      .offset(mcu_addr[11:0]),
      .buf_addr(frame_addr)
   );

   assign lin_addr = {page_reg, mcu_addr[14:0]};
   assign buf_next = (region == MBM_REGION_LINEAR) ? lin_addr :
      (region == MBM_REGION_FRAME) ? frame_addr : 20'h00000;
   // Data strobes reach DRAM only outside the register and unused ranges
   assign dram_next = data_acc && !data_as_program &&
      (region == MBM_REGION_LINEAR || region == MBM_REGION_FRAME);
   assign prog_top = program_window_enable ? sel_top : mcu_addr[15];
   assign prog_next = {prog_top ^ (invert_top_address_bit & data_acc),
      mcu_addr[14:0]};
   assign frm_load = frm_pend_reg && !frm_busy_reg;
   assign rd_next = (mcu_addr == MBM_PROG_CTRL_ADDR) ? prog_ctrl_reg :
      (mcu_addr == MBM_PAGE_ADDR) ? {{(8 - MBM_PAGE_W){1'b0}}, page_reg} :
      (mcu_addr == MBM_FRM_LO_ADDR) ? micro_frame_number[7:0] :
      (mcu_addr == MBM_FRM_HI_ADDR) ? {7'h00, micro_frame_number[8]} : 8'h00;

   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         prog_ctrl_reg <= MBM_PROG_CTRL_RESET;
         page_reg <= MBM_PAGE_RESET[MBM_PAGE_W-1:0];
         frm_lo_reg <= 8'h00;
         micro_frame_number <= MBM_FRAME_RESET;
         frm_pend_reg <= 1'b0;
         frm_pend_val_reg <= MBM_FRAME_RESET;
         frm_busy_reg <= 1'b0;
         cur_lin_reg <= 1'b0;
         cur_addr_reg <= 16'h0000;
      end
      else if (clk_en)
      begin
         if (mcu_data_wr && mcu_addr == MBM_PROG_CTRL_ADDR)
            prog_ctrl_reg <= {mcu_wdata[7:4], 4'h0};
         if (mcu_data_wr && mcu_addr == MBM_PAGE_ADDR)
            page_reg <= mcu_wdata[MBM_PAGE_W-1:0];
         if (mcu_data_wr && mcu_addr == MBM_FRM_LO_ADDR)
            frm_lo_reg <= mcu_wdata;
         if (mcu_data_wr && mcu_addr == MBM_FRM_HI_ADDR)
         begin
            frm_pend_reg <= 1'b1;
            frm_pend_val_reg <= {mcu_wdata[0], frm_lo_reg};
         end
         else if (frm_load)
            frm_pend_reg <= 1'b0;
         if (frm_load)
            micro_frame_number <= frm_pend_val_reg;
         if (dram_next)
         begin
            frm_busy_reg <= (region == MBM_REGION_FRAME);
            cur_lin_reg <= (region == MBM_REGION_LINEAR);
            cur_addr_reg <= mcu_addr;
         end
         else if (dram_done)
         begin
            frm_busy_reg <= 1'b0;
            cur_lin_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         buf_addr_reg <= 20'h00000;
         dram_req_reg <= 1'b0;
         prog_addr_reg <= 16'h0000;
         prog_req_reg <= 1'b0;
         reg_sel_reg <= 1'b0;
         reg_rdata_reg <= 8'h00;
      end
      else if (clk_en)
      begin
         if (dram_next)
            buf_addr_reg <= buf_next;
         else if (cur_lin_reg)
            buf_addr_reg <= {page_reg, cur_addr_reg[14:0]};
         else if (!frm_busy_reg)
            buf_addr_reg <= 20'h00000;
         dram_req_reg <= dram_next;
         prog_addr_reg <= prog_next;
         prog_req_reg <= mcu_prog_rd | (data_acc & data_as_program);
         reg_sel_reg <= data_acc && region == MBM_REGION_CTRL;
         reg_rdata_reg <= (mcu_data_rd && region == MBM_REGION_CTRL) ? rd_next : 8'h00;
      end
   end

   assign buf_addr = buf_addr_reg;
   assign dram_req = dram_req_reg;
   assign prog_addr = prog_addr_reg;
   assign prog_req = prog_req_reg;
   assign reg_sel = reg_sel_reg;
   assign reg_rdata = reg_rdata_reg;

   no_dram_ctrl_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      clk_en && data_acc && region == MBM_REGION_CTRL |=> !dram_req)
      else $error("control register access started a DRAM cycle");
   unused_low_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      clk_en && data_acc && region == MBM_REGION_UNUSED && !frm_busy_reg && !cur_lin_reg
      |=> !dram_req && buf_addr == 20'h00000)
      else $error("unused range reached the buffer");
   data_as_program_block_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      clk_en && data_acc && data_as_program |=> !dram_req && prog_req)
      else $error("data-as-program did not steer access");
   linear_addr_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      clk_en && data_acc && !data_as_program && !mcu_addr[15]
      |=> buf_addr == {$past(page_reg), $past(mcu_addr[14:0])})
      else $error("linear address wrong");
   page_live_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      clk_en && cur_lin_reg && !dram_next |=> buf_addr[19:15] == $past(page_reg))
      else $error("page change not applied to running cycle");
   frame_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      frm_busy_reg && !dram_done |=> $stable(micro_frame_number))
      else $error("frame counter changed during frame access");
   frame_lo_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      clk_en && mcu_data_wr && mcu_addr == MBM_FRM_LO_ADDR && !frm_pend_reg
      |=> $stable(micro_frame_number))
      else $error("low byte write loaded counter");
   window_top_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      clk_en && program_window_enable && !invert_top_address_bit
      |=> prog_addr[15] == $past(sel_top))
      else $error("program window select wrong");
   invert_off_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      clk_en && !data_as_program |=> prog_addr == $past(mcu_addr))
      else $error("remap active without data-as-program");
endmodule

// [test/mbm_dram_model.sv]
// Buffer manager stand-in: answers each DRAM request with one done pulse.
// Assumes dram_req is a one-cycle pulse on ref_clk; slow stretches the access.
`timescale 1ns/10ps
module mbm_dram_model
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic dram_req,
   input wire logic slow,
   output logic dram_done
);
   logic [3:0] left_reg;
   always_ff @(posedge ref_clk)
   begin
      dram_done <= resetn && left_reg == 4'h1;
      if (!resetn)
         left_reg <= 4'h0;
      else if (dram_req)
         left_reg <= slow ? 4'h9 : 4'h1;
      else if (left_reg != 4'h0)
         left_reg <= left_reg - 4'h1;
   end
endmodule

// [test/mbm_mapper_tb_top.sv]
// Self-checking bench for the buffer address mapper.
// Assumes mbm_pkg; a model plays the buffer manager's DRAM side.
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
   $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module mbm_mapper_tb_top;
   import mbm_pkg::*;
   logic ref_clk, resetn, mcu_data_rd, mcu_data_wr, mcu_prog_rd, slow;
   logic dram_req, dram_done, prog_req, reg_sel;
   logic [15:0] mcu_addr, prog_addr, w, ep;
   logic [7:0] mcu_wdata, reg_rdata, er;
   logic [8:0] start_frame_pointer, last_frame_pointer;
   logic [19:0] buf_addr, ed;
   logic [19:0] q_dram[$];
   logic [15:0] q_prog[$];
   logic [7:0] q_reg[$];
   logic [7:0] pm[5];
   logic [7:0] pc;
   logic [14:0] a;
   logic [4:0] pg;
   int checks, miscompares, cycles;
   mbm_mapper u_mbm_mapper(.ref_clk(ref_clk), .resetn(resetn), .clk_en(1'b1),
      .mcu_addr(mcu_addr), .mcu_wdata(mcu_wdata), .mcu_data_rd(mcu_data_rd),
      .mcu_data_wr(mcu_data_wr), .mcu_prog_rd(mcu_prog_rd), .dram_done(dram_done),
      .start_frame_pointer(start_frame_pointer), .last_frame_pointer(last_frame_pointer),
      .buf_addr(buf_addr), .dram_req(dram_req), .prog_addr(prog_addr),
      .prog_req(prog_req), .reg_sel(reg_sel), .reg_rdata(reg_rdata));
   mbm_dram_model u_mbm_dram_model(.ref_clk(ref_clk), .resetn(resetn),
      .dram_req(dram_req), .slow(slow), .dram_done(dram_done));
   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   task automatic give_verdict();
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Each result pulse takes the oldest expectation of its kind
   always @(posedge ref_clk)
   begin
      cycles++;
      if (resetn && dram_req)
      begin
         ed = q_dram.size() ? q_dram.pop_front() : 'x;
         `CHK(buf_addr, ed)
      end
      if (resetn && prog_req)
      begin
         ep = q_prog.size() ? q_prog.pop_front() : 'x;
         `CHK(prog_addr, ep)
      end
      if (resetn && reg_sel)
      begin
         er = q_reg.size() ? q_reg.pop_front() : 'x;
         `CHK(reg_rdata, er)
      end
      if (cycles == 3000)
      begin
         miscompares++;
         give_verdict();
      end
   end
   task automatic strobe(input logic [15:0] ad, input logic [7:0] d, input logic [2:0] k);
      @(posedge ref_clk);
      mcu_addr <= ad;
      mcu_wdata <= d;
      {mcu_data_rd, mcu_data_wr, mcu_prog_rd} <= k;
      @(posedge ref_clk);
      {mcu_data_rd, mcu_data_wr, mcu_prog_rd} <= 3'b000;
   endtask
   task automatic wr(input logic [15:0] ad, input logic [7:0] d);
      q_reg.push_back(8'h00);
      strobe(ad, d, 3'b010);
   endtask
   task automatic rd(input logic [15:0] ad, input logic [7:0] e);
      q_reg.push_back(e);
      strobe(ad, 8'h00, 3'b100);
   endtask
   task automatic wait_done();
      int n;
      n = 0;
      while (dram_done !== 1'b1 && n < 20)
      begin
         @(posedge ref_clk);
         n++;
      end
      `CHK(n < 20, 1'b1)
   endtask
   task automatic dacc(input logic [15:0] ad, input logic [19:0] e, input bit wt);
      q_dram.push_back(e);
      strobe(ad, 8'h00, 3'b100);
      if (wt)
         wait_done();
   endtask
   task automatic setf(input logic [8:0] fr);
      wr(MBM_FRM_LO_ADDR, fr[7:0]);
      wr(MBM_FRM_HI_ADDR, {7'h00, fr[8]});
   endtask
   task automatic settle_chk(input logic [19:0] e);
      repeat (2) @(posedge ref_clk);
      #1;
      `CHK(buf_addr, e)
   endtask
   function automatic logic [19:0] fexp(input logic [8:0] fr, input int k, input logic [11:0] o);
      int n;
      n = fr + k;
      if (n > last_frame_pointer)
         n = start_frame_pointer + n - last_frame_pointer - 1;
      return 20'(n * 3072) + 20'(o);
   endfunction
   // Program address for control value c; dat marks a data access
   function automatic logic [15:0] pexp(input logic [7:0] c, input logic [15:0] ad,
      input bit dat);
      logic t;
      t = (c[MBM_PRG_DATA_BIT] && c[MBM_PRG_WIN_BIT]) ? c[MBM_PRG_TOP_BIT] : ad[15];
      return {t ^ (c[MBM_PRG_DATA_BIT] & c[MBM_PRG_INV_BIT] & dat), ad[14:0]};
   endfunction
   initial
   begin
      {resetn, mcu_data_rd, mcu_data_wr, mcu_prog_rd, slow} = 5'b00000;
      mcu_addr = 16'h0000;
      mcu_wdata = 8'h00;
      start_frame_pointer = 9'h00a;
      last_frame_pointer = 9'h014;
      void'($urandom(92320));
      repeat (2) @(posedge ref_clk);
      resetn <= 1'b1;
      rd(MBM_PAGE_ADDR, MBM_PAGE_RESET);
      rd(MBM_PROG_CTRL_ADDR, MBM_PROG_CTRL_RESET);
      repeat (4)
      begin
         pg = 5'($urandom);
         a = 15'($urandom);
         wr(MBM_PAGE_ADDR, {3'h0, pg});
         rd(MBM_PAGE_ADDR, {3'h0, pg});
         dacc({1'b0, a}, {pg, a}, 1);
         strobe(16'hb000 + 16'($urandom_range(16'h3fff)), 8'h00, 3'b100);
         settle_chk(20'h00000);
         rd(16'hf0e0, 8'h00);
      end
      for (int f = 17; f <= 20; f++)
      begin
         setf(9'(f));
         for (int k = 0; k < 3; k++)
         begin
            a = 15'($urandom);
            dacc(16'h8000 + 16'(k << 12) + 16'(a[11:0]), fexp(9'(f), k, a[11:0]), 1);
         end
      end
      wr(MBM_FRM_LO_ADDR, 8'h0b);
      dacc(16'h8123, fexp(9'h014, 0, 12'h123), 1);
      wr(MBM_FRM_HI_ADDR, 8'h00);
      dacc(16'h8123, fexp(9'h00b, 0, 12'h123), 1);
      slow <= 1'b1;
      dacc(16'h8456, fexp(9'h00b, 0, 12'h456), 0);
      setf(9'h00c);
      rd(MBM_FRM_LO_ADDR, 8'h0b);
      settle_chk(fexp(9'h00b, 0, 12'h456));
      wait_done();
      dacc(16'h8456, fexp(9'h00c, 0, 12'h456), 1);
      a = 15'($urandom);
      dacc({1'b0, a}, {pg, a}, 0);
      pg = ~pg;
      wr(MBM_PAGE_ADDR, {3'h0, pg});
      settle_chk({pg, a});
      wait_done();
      pm = '{8'h10, 8'h80, 8'h90, 8'hc0, 8'he0};
      pc = MBM_PROG_CTRL_RESET;
      // Register accesses are data accesses too and follow the steering
      foreach (pm[i])
      begin
         if (pc[MBM_PRG_DATA_BIT])
            q_prog.push_back(pexp(pc, MBM_PROG_CTRL_ADDR, 1'b1));
         wr(MBM_PROG_CTRL_ADDR, pm[i]);
         pc = pm[i] & 8'hf0;
         if (pc[MBM_PRG_DATA_BIT])
            q_prog.push_back(pexp(pc, MBM_PROG_CTRL_ADDR, 1'b1));
         rd(MBM_PROG_CTRL_ADDR, pc);
         a = 15'($urandom);
         if (!pc[MBM_PRG_DATA_BIT])
            dacc({1'b0, a}, {pg, a}, 1);
         else
         begin
            q_prog.push_back(pexp(pc, {1'b0, a}, 1'b1));
            strobe({1'b0, a}, 8'h00, 3'b100);
         end
         w = 16'($urandom);
         q_prog.push_back(pexp(pc, w, 1'b0));
         strobe(w, 8'h00, 3'b001);
      end
      if (pc[MBM_PRG_DATA_BIT])
         q_prog.push_back(pexp(pc, MBM_PROG_CTRL_ADDR, 1'b1));
      wr(MBM_PROG_CTRL_ADDR, 8'h00);
      repeat (3) @(posedge ref_clk);
      `CHK(q_dram.size() + q_prog.size() + q_reg.size(), 0)
      give_verdict();
   end
endmodule
